// ==== hw/vfd_scan_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the display scan block
`ifndef VFD_SCAN_REGS_SVH
`define VFD_SCAN_REGS_SVH
`define VFD_ADDR_PIN_COUNT 16'hff69
`define VFD_ADDR_BLANK_PAT 16'hff6a
`define VFD_ADDR_KEYSCAN 16'hff92
`define VFD_RST_PIN_COUNT 8'h10
`define VFD_RST_BLANK_PAT 8'h01
`define VFD_RST_KEYSCAN 8'h00
`define VFD_BIT_DISPLAY_ON 7
`define VFD_BIT_KS_FLAG 7
`define VFD_BIT_KS_MODE 6
`define VFD_PIN_LSB 0
`define VFD_PIN_MSB 5
`define VFD_BLANK_LSB 5
`define VFD_BLANK_MSB 7
`define VFD_PAT_LSB 0
`define VFD_PAT_MSB 4
`define VFD_CYC_LSB 0
`define VFD_CYC_MSB 1
`define VFD_MEM_BASE 16'hfa00
`define VFD_MEM_BYTES 112
`define VFD_SLOT_BYTES 7
`define VFD_PIN_CODE_MIN 6'h10
`define VFD_PIN_CODE_OFS 6'h01
`define VFD_LOG2_CYC_LONG 12
`define VFD_PORT_PIN_FIRST 24
`define VFD_NUM_PINS 53
`endif

// ==== hw/vfd_pkg.sv ====
// Types shared by the display scan block
package vfd_pkg;
  typedef enum logic [1:0] {
    VFD_IDLE = 2'b00,
    VFD_PATTERN = 2'b01,
    VFD_KEYSCAN = 2'b10
  } vfd_slot_state_t;
endpackage : vfd_pkg

// ==== hw/vfd_blank_calc.sv ====
// Blanking edge lookup: cycles of blanking at each end of a display period
`include "vfd_scan_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module vfd_blank_calc (
  input wire logic [2:0] blank_code,
  input wire logic [1:0] cycle_code,
  output logic [11:0] blank_half
);
  logic [4:0] sixteenths;
  logic [3:0] shift;
  // Width in sixteenths, halved, scaled by period
  always_comb begin
    case (blank_code)
      3'h0: sixteenths = 5'h01;
      3'h1: sixteenths = 5'h02;
      3'h2: sixteenths = 5'h04;
      3'h3: sixteenths = 5'h06;
      3'h4: sixteenths = 5'h08;
      3'h5: sixteenths = 5'h0a;
      3'h6: sixteenths = 5'h0c;
      default: sixteenths = 5'h0e;
    endcase
    shift = 4'(`VFD_LOG2_CYC_LONG - 5) - {2'h0, cycle_code};
    blank_half = 12'({7'h00, sixteenths} << shift);
  end
endmodule : vfd_blank_calc
`default_nettype wire

// ==== hw/vfd_display_ram.sv ====
// Dual-port display data memory: CPU port and scan fetch port
`include "vfd_scan_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module vfd_display_ram #(
  parameter int DEPTH = `VFD_MEM_BYTES
) (
  input wire logic clk,
  input wire logic cpu_we,
  input wire logic [6:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic [6:0] scan_addr,
  output logic [7:0] scan_rdata
);
  // Elaboration check: seven address bits reach 128 bytes at most
  if (DEPTH < 1 || DEPTH > 128) begin : g_bad_depth
    $error("vfd_display_ram depth must be 1 to 128");
  end
  logic [7:0] mem [DEPTH];
  // CPU write and both reads, registered
  always_ff @(posedge clk) begin
    if (cpu_we && 32'(cpu_addr) < DEPTH) begin
      mem[cpu_addr] <= cpu_wdata;
    end
    cpu_rdata <= (32'(cpu_addr) < DEPTH) ? mem[cpu_addr] : 8'h00;
    scan_rdata <= (32'(scan_addr) < DEPTH) ? mem[scan_addr] : 8'h00;
  end
endmodule : vfd_display_ram
`default_nettype wire

// ==== hw/vfd_display_scan_timing.sv ====
// Display scan controller: registers, slot sequencer, memory fetch and output drive
`include "vfd_scan_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module vfd_display_scan_timing #(
  parameter int NUM_PINS = `VFD_NUM_PINS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic [28:0] port_latch,
  output logic [52:0] display_outputs,
  output logic [28:0] port_pin_select,
  output logic keyscan_active_flag
);
  localparam int SLOT_BYTES = `VFD_SLOT_BYTES;
  localparam int PORT_FIRST = `VFD_PORT_PIN_FIRST;

  // Elaboration check: the memory layout serves exactly 53 pins
  if (NUM_PINS != `VFD_NUM_PINS) begin : g_bad_pins
    $error("vfd_display_scan_timing supports 53 display outputs only");
  end

  logic [7:0] display_enable_pin_count_ff;
  logic [7:0] blanking_pattern_config_ff;
  logic [2:0] keyscan_cycle_control_ff;
  vfd_pkg::vfd_slot_state_t state_ff;
  vfd_pkg::vfd_slot_state_t nxt_state;
  logic [11:0] tick_ff;
  logic [3:0] slot_ff;
  logic [2:0] byte_ff;
  logic [55:0] shift_ff;
  logic [52:0] slot_data_ff;
  logic [7:0] scan_byte;
  logic [7:0] ram_rdata;
  logic [11:0] blank_half;
  logic [11:0] period_last;
  logic [6:0] scan_addr;
  logic [6:0] ram_addr;
  logic ram_sel;
  logic ram_sel_ff;
  logic slot_end;
  logic fetch_valid_ff;
  logic in_blank;
  logic display_on;
  logic ks_mode;
  logic [5:0] active_pins;
  logic [52:0] pin_enabled;
  logic [3:0] pattern_last;

  assign display_on = display_enable_pin_count_ff[`VFD_BIT_DISPLAY_ON];
  assign ks_mode = keyscan_cycle_control_ff[2];
  // Count code 010000 maps to 17 pins; prohibited codes are not guarded
  assign active_pins = display_enable_pin_count_ff[`VFD_PIN_MSB:`VFD_PIN_LSB]
                       + `VFD_PIN_CODE_OFS;
  assign pattern_last = blanking_pattern_config_ff[3:0];
  assign period_last = 12'((13'h1000 >> keyscan_cycle_control_ff[1:0]) - 13'h1);
  assign ram_sel = (cpu_addr >= `VFD_MEM_BASE) &&
                   (cpu_addr < `VFD_MEM_BASE + 16'(`VFD_MEM_BYTES));
  assign ram_addr = 7'(cpu_addr - `VFD_MEM_BASE);
  assign scan_addr = 7'(slot_ff * 7'(SLOT_BYTES)) + {4'h0, byte_ff};
  assign slot_end = (tick_ff == period_last);

  vfd_blank_calc u_blank (
    .blank_code(blanking_pattern_config_ff[`VFD_BLANK_MSB:`VFD_BLANK_LSB]),
    .cycle_code(keyscan_cycle_control_ff[1:0]),
    .blank_half(blank_half)
  );

  // Display memory shared with the CPU; unused blocks are plain RAM
  vfd_display_ram u_ram (
    .clk(clk),
    .cpu_we(cpu_wr && ram_sel),
    .cpu_addr(ram_addr),
    .cpu_wdata(cpu_wdata),
    .cpu_rdata(ram_rdata),
    .scan_addr(scan_addr),
    .scan_rdata(scan_byte)
  );

  // Control register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      display_enable_pin_count_ff <= `VFD_RST_PIN_COUNT;
      blanking_pattern_config_ff <= `VFD_RST_BLANK_PAT;
      keyscan_cycle_control_ff <= 3'h0;
    end else if (cpu_wr) begin
      if (cpu_addr == `VFD_ADDR_PIN_COUNT) begin
        display_enable_pin_count_ff <= cpu_wdata & 8'hbf;
      end
      if (cpu_addr == `VFD_ADDR_BLANK_PAT) begin
        blanking_pattern_config_ff <= cpu_wdata;
      end
      if (cpu_addr == `VFD_ADDR_KEYSCAN) begin
        keyscan_cycle_control_ff <= {cpu_wdata[`VFD_BIT_KS_MODE],
                                     cpu_wdata[`VFD_CYC_MSB:`VFD_CYC_LSB]};
      end
    end
  end

  // Register read data one cycle after the read strobe, memory read data two cycles after
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_sel_ff <= 1'b0;
      cpu_rdata <= 8'h00;
    end else begin
      ram_sel_ff <= cpu_rd && ram_sel;
      if (cpu_rd && cpu_addr == `VFD_ADDR_PIN_COUNT) begin
        cpu_rdata <= display_enable_pin_count_ff;
      end else if (cpu_rd && cpu_addr == `VFD_ADDR_BLANK_PAT) begin
        cpu_rdata <= blanking_pattern_config_ff;
      end else if (cpu_rd && cpu_addr == `VFD_ADDR_KEYSCAN) begin
        cpu_rdata <= {keyscan_active_flag, keyscan_cycle_control_ff[2], 4'h0,
                      keyscan_cycle_control_ff[1:0]};
      end else if (ram_sel_ff) begin
        cpu_rdata <= ram_rdata;
      end else begin
        cpu_rdata <= 8'h00;
      end
    end
  end

  // Slot sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      vfd_pkg::VFD_IDLE: begin
        if (display_on) begin
          nxt_state = vfd_pkg::VFD_PATTERN;
        end
      end
      vfd_pkg::VFD_PATTERN: begin
        if (!display_on) begin
          nxt_state = vfd_pkg::VFD_IDLE;
        end else if (slot_end && slot_ff == pattern_last && ks_mode) begin
          nxt_state = vfd_pkg::VFD_KEYSCAN;
        end
      end
      vfd_pkg::VFD_KEYSCAN: begin
        if (!display_on) begin
          nxt_state = vfd_pkg::VFD_IDLE;
        end else if (slot_end) begin
          nxt_state = vfd_pkg::VFD_PATTERN;
        end
      end
      default: nxt_state = vfd_pkg::VFD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= vfd_pkg::VFD_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Period tick counter and slot index
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_ff <= 12'h000;
      slot_ff <= 4'h0;
    end else if (state_ff == vfd_pkg::VFD_IDLE) begin
      tick_ff <= 12'h000;
      slot_ff <= 4'h0;
    end else if (slot_end) begin
      tick_ff <= 12'h000;
      if (state_ff == vfd_pkg::VFD_KEYSCAN || slot_ff == pattern_last) begin
        slot_ff <= 4'h0;
      end else begin
        slot_ff <= slot_ff + 4'h1;
      end
    end else begin
      tick_ff <= tick_ff + 12'h001;
    end
  end

  // Fetch the seven bytes of the current slot at the start of each pattern period but the first after idle, which takes byte 1 twice
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_ff <= 3'h0;
      fetch_valid_ff <= 1'b0;
      shift_ff <= 56'h0;
    end else begin
      fetch_valid_ff <= (state_ff == vfd_pkg::VFD_PATTERN) && (tick_ff < 12'(SLOT_BYTES));
      if (tick_ff < 12'(SLOT_BYTES - 1)) begin
        byte_ff <= 3'(tick_ff + 12'h001);
      end else begin
        byte_ff <= 3'h0;
      end
      if (fetch_valid_ff) begin
        shift_ff <= {scan_byte, shift_ff[55:8]};
      end
    end
  end

  // Latch assembled block once fetch finishes, well inside the blank
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_data_ff <= 53'h0;
    end else if (tick_ff == 12'(SLOT_BYTES + 1)) begin
      slot_data_ff <= shift_ff[52:0];
    end
  end

  // Blank at both ends of the period
  assign in_blank = (tick_ff < blank_half + 12'(SLOT_BYTES + 2)) ||
                    (tick_ff > period_last - blank_half);

  // Pins below the configured count are display pins
  genvar gp;
  for (gp = 0; gp < 53; gp++) begin : g_pin_en
    assign pin_enabled[gp] = display_on && (6'(gp) < active_pins);
  end

  // Output drive per pin; in the key-scan slot pins 24 to 52 carry port_latch and pins 0 to 23 stay low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      display_outputs <= 53'h0;
      port_pin_select <= 29'h1fffffff;
      keyscan_active_flag <= 1'b0;
    end else begin
      keyscan_active_flag <= (nxt_state == vfd_pkg::VFD_KEYSCAN);
      if (nxt_state == vfd_pkg::VFD_KEYSCAN) begin
        display_outputs <= {port_latch, 24'h000000};
        port_pin_select <= 29'h1fffffff;
      end else begin
        for (int i = 0; i < 53; i++) begin
          display_outputs[i] <= pin_enabled[i] && !in_blank &&
                                state_ff == vfd_pkg::VFD_PATTERN &&
                                slot_data_ff[i];
        end
        port_pin_select <= ~pin_enabled[52:PORT_FIRST];
      end
    end
  end
endmodule : vfd_display_scan_timing
`default_nettype wire

// ==== verification/vfd_scan_sva.sv ====
// Port checker for the display scan block
`timescale 1ns/1ps
`default_nettype none
module vfd_scan_sva #(
  parameter int NUM_PINS = 53
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic [28:0] port_latch,
  input wire logic [52:0] display_outputs,
  input wire logic [28:0] port_pin_select,
  input wire logic keyscan_active_flag
);
  logic on_ff;
  logic ks_ff;
  logic [5:0] pc_ff;
  logic [2:0] off_ff;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Shadow of software settings and cycles since display off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_ff <= 1'b0;
      ks_ff <= 1'b0;
      pc_ff <= 6'h10;
      off_ff <= 3'h4;
    end else begin
      if (cpu_wr && cpu_addr == 16'hff69) begin
        on_ff <= cpu_wdata[7];
        pc_ff <= cpu_wdata[5:0];
      end
      if (cpu_wr && cpu_addr == 16'hff92) begin
        ks_ff <= cpu_wdata[6];
      end
      if (on_ff) begin
        off_ff <= 3'h0;
      end else if (off_ff != 3'h4) begin
        off_ff <= off_ff + 3'h1;
      end
    end
  end
  property p_ks_dark;
    keyscan_active_flag |-> display_outputs[23:0] == '0 &&
      display_outputs[52:24] == $past(port_latch) && port_pin_select == '1;
  endproperty
  a_ks_dark: assert property (p_ks_dark) else $error("outputs live in key-scan slot");
  property p_ks_hold;
    $rose(keyscan_active_flag) |-> keyscan_active_flag [*8];
  endproperty
  a_ks_hold: assert property (p_ks_hold) else $error("key-scan flag too short");
  property p_ks_mode;
    $rose(keyscan_active_flag) |-> ks_ff;
  endproperty
  a_ks_mode: assert property (p_ks_mode) else $error("key-scan slot not enabled");
  property p_off_dark;
    off_ff == 3'h4 |-> display_outputs == '0 && port_pin_select == '1 && !keyscan_active_flag;
  endproperty
  a_off_dark: assert property (p_off_dark) else $error("display active while off");
  property p_pin_range;
    (display_outputs >> (pc_ff + 7'd1)) == '0;
  endproperty
  a_pin_range: assert property (p_pin_range) else $error("pin above count driven");
  property p_rd_flag;
    cpu_rd && cpu_addr == 16'hff92 |=>
      cpu_rdata[7] == $past(keyscan_active_flag) && cpu_rdata[5:2] == 4'h0;
  endproperty
  a_rd_flag: assert property (p_rd_flag) else $error("key-scan read wrong");
  property p_rd_res;
    cpu_rd && cpu_addr == 16'hff69 |=> cpu_rdata[6] == 1'b0;
  endproperty
  a_rd_res: assert property (p_rd_res) else $error("reserved bit read high");
  property p_start_blank;
    $fell(keyscan_active_flag) |-> (display_outputs == '0) [*8];
  endproperty
  a_start_blank: assert property (p_start_blank) else $error("no start blanking");
  property p_end_blank;
    $rose(keyscan_active_flag) |-> $past(display_outputs) == '0;
  endproperty
  a_end_blank: assert property (p_end_blank) else $error("no end blanking");
endmodule : vfd_scan_sva
bind vfd_display_scan_timing vfd_scan_sva #(.NUM_PINS(NUM_PINS)) u_sva (.clk(clk),
  .rst_n(rst_n), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr),
  .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .port_latch(port_latch),
  .display_outputs(display_outputs), .port_pin_select(port_pin_select),
  .keyscan_active_flag(keyscan_active_flag));
`default_nettype wire

// ==== verification/vfd_panel_model.sv ====
// Display panel model counting lit and key-scan cycles
`timescale 1ns/1ps
`default_nettype none
module vfd_panel_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [52:0] display_outputs,
  input wire logic keyscan_active_flag,
  output logic [15:0] lit_cnt,
  output logic [15:0] ks_cnt
);
  // Any driven line lights, grid or segment alike
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lit_cnt <= 16'h0000;
      ks_cnt <= 16'h0000;
    end else begin
      lit_cnt <= lit_cnt + {15'h0000, |display_outputs};
      ks_cnt <= ks_cnt + {15'h0000, keyscan_active_flag};
    end
  end
endmodule : vfd_panel_model
`default_nettype wire

// ==== verification/test_vfd_display_scan_timing.sv ====
// Testbench for the display scan block
`timescale 1ns/1ps
`default_nettype none
module test_vfd_display_scan_timing;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_wdata = 8'h00;
  logic [28:0] port_latch = 29'h0;
  logic [7:0] cpu_rdata;
  logic [52:0] display_outputs;
  logic [28:0] port_pin_select;
  logic keyscan_active_flag;
  logic [15:0] lit_cnt;
  logic [15:0] ks_cnt;
  logic [15:0] snap;
  logic [5:0] cur_pc = 6'h10;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  // Clock and hang guard
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      err_count++;
      report_and_stop();
    end
  end
  vfd_display_scan_timing dut (.clk(clk), .rst_n(rst_n), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .port_latch(port_latch), .display_outputs(display_outputs),
    .port_pin_select(port_pin_select), .keyscan_active_flag(keyscan_active_flag));
  vfd_panel_model u_panel (.clk(clk), .rst_n(rst_n), .display_outputs(display_outputs),
    .keyscan_active_flag(keyscan_active_flag), .lit_cnt(lit_cnt), .ks_cnt(ks_cnt));
  task automatic chk(input logic [52:0] s, input logic [52:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    cpu_wr = 1'b1;
    cpu_addr = a;
    cpu_wdata = d;
    @(negedge clk);
    cpu_wr = 1'b0;
  endtask : wr
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    cpu_rd = 1'b1;
    cpu_addr = a;
    @(negedge clk);
    cpu_rd = 1'b0;
    chk(cpu_rdata, e);
  endtask : rdc
  task automatic rdm(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    cpu_rd = 1'b1;
    cpu_addr = a;
    @(negedge clk);
    cpu_rd = 1'b0;
    @(negedge clk);
    chk(cpu_rdata, e);
  endtask : rdm
  task automatic wait_flag(input logic lv);
    int n;
    n = 0;
    while (keyscan_active_flag !== lv && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (n == 20000) begin
      err_count++;
      $display("ERROR %0t: flag wait timed out", $time);
    end
  endtask : wait_flag
  function automatic logic [7:0] byte_of(input int a);
    return 8'(a * 19) ^ 8'h5a;
  endfunction : byte_of
  function automatic logic [52:0] exp_slot(input int s);
    logic [55:0] v;
    for (int i = 0; i < 7; i++) v[i*8 +: 8] = byte_of(s * 7 + i);
    return v[52:0];
  endfunction : exp_slot
  // Turn off, set up, turn back on
  task automatic cfg(input logic [5:0] pc, input logic [7:0] bp, input logic [7:0] ks);
    wr(16'hff69, {2'b00, cur_pc});
    wr(16'hff69, {2'b00, pc});
    cur_pc = pc;
    wr(16'hff6a, bp);
    wr(16'hff92, ks);
    wr(16'hff69, {2'b10, pc});
  endtask : cfg
  task automatic t_reset_regs();
    rdc(16'hff69, 8'h10);
    rdc(16'hff6a, 8'h01);
    rdc(16'hff92, 8'h00);
    rdc(16'hff00, 8'h00);
    wr(16'hff92, 8'hc2);
    rdc(16'hff92, 8'h42);
    wr(16'hfa6f, 8'h3c);
    rdm(16'hfa6f, 8'h3c);
    $display("test reset_regs done");
  endtask : t_reset_regs
  task automatic t_slot_data();
    for (int i = 0; i < 14; i++) wr(16'hfa00 + 16'(i), byte_of(i));
    cfg(6'h34, 8'h01, 8'h42);
    wait_flag(1'b1);
    wait_flag(1'b0);
    repeat (512) @(negedge clk);
    chk(display_outputs, exp_slot(0));
    repeat (1024) @(negedge clk);
    chk(display_outputs, exp_slot(1));
    wait_flag(1'b1);
    chk(display_outputs, 53'h0);
    chk(port_pin_select, 29'h1fffffff);
    rdc(16'hff92, 8'hc2);
    $display("test slot_data done");
  endtask : t_slot_data
  task automatic t_blank();
    for (int c = 0; c < 8; c++) begin
      cfg(6'h34, {c[2:0], 5'h01}, 8'h42);
      wait_flag(1'b1);
      wait_flag(1'b0);
      snap = lit_cnt;
      repeat (1024) @(negedge clk);
      chk(lit_cnt - snap, 16'(1015 - 64 * ((c == 0) ? 1 : 2 * c)));
    end
    $display("test blank done");
  endtask : t_blank
  task automatic t_cycles();
    for (int c = 0; c < 3; c++) begin
      cfg(6'h34, 8'h01, {6'h10, c[1:0]});
      wait_flag(1'b1);
      snap = ks_cnt;
      wait_flag(1'b0);
      chk(ks_cnt - snap, 16'(4096 >> c));
    end
    $display("test cycles done");
  endtask : t_cycles
  task automatic t_pins17();
    port_latch = 29'h15555555;
    cfg(6'h10, 8'h01, 8'h02);
    snap = ks_cnt;
    repeat (3072) @(negedge clk);
    chk(ks_cnt - snap, 16'h0000);
    chk(port_pin_select, 29'h1fffffff);
    chk(display_outputs >> 17, 53'h0);
    wr(16'hff69, 8'h10);
    repeat (4) @(negedge clk);
    chk(display_outputs, 53'h0);
    $display("test pins17 done");
  endtask : t_pins17
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_reset_regs();
    t_slot_data();
    t_blank();
    t_cycles();
    t_pins17();
    report_and_stop();
  end
endmodule : test_vfd_display_scan_timing
`default_nettype wire
